// ==== timer_regs.vh ====
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH
// Register indices (byte addresses on the plain port)
`define ADDR_CTRL_A      4'h0
`define ADDR_CTRL_B      4'h1
`define ADDR_COUNT       4'h2
`define ADDR_COMPARE     4'h3
`define ADDR_ASYNC_STAT  4'h4
`define ADDR_IRQ_MASK    4'h5
`define ADDR_IRQ_FLAG    4'h6
`define ADDR_SYS_CLK     4'h7
// Field positions
`define CTRLB_FORCE_BIT  7
`define ASR_EXT_BIT      6
`define ASR_ASYNC_BIT    5
`define ASR_CNT_UB       4
`define ASR_CMP_UB       3
`define ASR_CA_UB        1
`define ASR_CB_UB        0
`define IRQ_CMP_BIT      1
`define IRQ_OVF_BIT      0
// Reset values
`define RST_BYTE         8'h00
// Counter limits
`define CNT_BOTTOM       8'h00
`define CNT_MAX          8'hFF
// Waveform modes
`define WGM_NORMAL       2'b00
`define WGM_PHASE        2'b01
`define WGM_CTC          2'b10
`define WGM_FAST         2'b11
// Async transfer latency in clk cycles (two-flop crossing)
`define UB_SYNC_CYCLES   2
`endif

// ==== prescale_tap.v ====
`timescale 1ns/1ps
`default_nettype none
// =========================================
// Prescaler: one-cycle tick per selected period
module prescale_tap (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Source clock enable and selection
  input wire srcTick,
  input wire [2:0] clockSelect,
  // Counting tick
  output reg cntTick
);
  reg [9:0] div_ff;
  reg tap;

  always @* begin
    case (clockSelect)
      3'h0: tap = 1'b0;
      3'h1: tap = srcTick;
      3'h2: tap = srcTick & (&div_ff[2:0]);
      3'h3: tap = srcTick & (&div_ff[4:0]);
      3'h4: tap = srcTick & (&div_ff[5:0]);
      3'h5: tap = srcTick & (&div_ff[6:0]);
      3'h6: tap = srcTick & (&div_ff[7:0]);
      default: tap = srcTick & (&div_ff[9:0]);
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      div_ff <= 10'h000;
      cntTick <= 1'b0;
    end else begin
      if (srcTick) begin
        div_ff <= div_ff + 10'h001;
      end
      cntTick <= tap;
    end
  end
endmodule // prescale_tap
`default_nettype wire

// ==== async_8bit_timer.v ====
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.vh"
module async_8bit_timer (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire [3:0] addr,
  input wire [7:0] wrData,
  input wire wrStb,
  input wire rdStb,
  output reg [7:0] rdData,
  // System context
  input wire globalIrqEnable,
  input wire sysClkIsRc,
  input wire compareVectorAck,
  input wire overflowVectorAck,
  input wire slowClockTick,
  // Outputs
  output reg compareOutputPin,
  output reg compareIrq,
  output reg overflowIrq,
  output reg extClockBufferEn,
  output reg crystalOscEn
);
  // =========================================
  // Software-visible temporaries
  reg [7:0] ctrlA_ff;
  reg [2:0] clkSel_ff;
  reg [7:0] compareTmp_ff;
  reg extEn_ff;
  reg asyncSel_ff;
  reg [1:0] irqMask_ff;
  reg cmpFlag_ff;
  reg ovfFlag_ff;
  // Active copies used by the timer
  reg [7:0] count_ff;
  reg [7:0] compare_ff;
  reg [7:0] ctrlAAct_ff;
  reg [2:0] clkSelAct_ff;
  reg countDown_ff;
  reg blockMatch_ff;
  // Busy flags and their crossing pipeline
  reg [3:0] busy_ff;
  reg [3:0] busyStage1_ff;
  reg [3:0] busyStage2_ff;
  reg slowSync1_ff;
  reg slowSync2_ff;
  reg slowPrev_ff;
  reg evtSync1_ff;
  reg evtSync2_ff;

  wire [1:0] wgm = ctrlAAct_ff[1:0];
  wire [1:0] com = ctrlAAct_ff[7:6];
  wire isPwm = wgm[0];
  wire asyncOn = asyncSel_ff;
  wire wrCtrlA = wrStb && addr == `ADDR_CTRL_A;
  wire wrCtrlB = wrStb && addr == `ADDR_CTRL_B;
  wire wrCount = wrStb && addr == `ADDR_COUNT;
  wire wrCmp = wrStb && addr == `ADDR_COMPARE;

  // =========================================
  // Source clock enable: I/O clock or synchronised slow edge
  wire slowEdge = slowSync2_ff & ~slowPrev_ff;
  wire srcTick = asyncOn ? slowEdge : 1'b1;
  wire cntTick;

  prescale_tap uPrescale (
    .clk(clk),
    .nrst(nrst),
    .srcTick(srcTick),
    .clockSelect(clkSelAct_ff),
    .cntTick(cntTick)
  );

  // =========================================
  // Counter and compare unit
  wire [7:0] topVal = (wgm == `WGM_CTC) ? compare_ff : `CNT_MAX;
  wire match = cntTick && !blockMatch_ff && count_ff == compare_ff;
  wire forceCmp = wrCtrlB && wrData[`CTRLB_FORCE_BIT] && !isPwm;
  reg [7:0] nxt_count;
  reg nxt_down;
  reg ovfEvt;

  always @* begin
    nxt_count = count_ff;
    nxt_down = countDown_ff;
    ovfEvt = 1'b0;
    if (cntTick) begin
      case (wgm)
        `WGM_PHASE: begin
          if (!countDown_ff) begin
            if (count_ff == `CNT_MAX) begin
              nxt_down = 1'b1;
              nxt_count = count_ff - 8'h01;
            end else begin
              nxt_count = count_ff + 8'h01;
            end
          end else if (count_ff == `CNT_BOTTOM) begin
            nxt_down = 1'b0;
            nxt_count = count_ff + 8'h01;
            ovfEvt = 1'b1;
          end else begin
            nxt_count = count_ff - 8'h01;
          end
        end
        default: begin
          nxt_down = 1'b0;
          if (count_ff == topVal) begin
            nxt_count = `CNT_BOTTOM;
          end else begin
            nxt_count = count_ff + 8'h01;
          end
          ovfEvt = (count_ff == `CNT_MAX);
        end
      endcase
    end
  end

  // Compare output action
  reg nxt_pin;

  always @* begin
    nxt_pin = compareOutputPin;
    if (!isPwm) begin
      if (match || forceCmp) begin
        case (com)
          2'b01: nxt_pin = ~compareOutputPin;
          2'b10: nxt_pin = 1'b0;
          2'b11: nxt_pin = 1'b1;
          default: nxt_pin = compareOutputPin;
        endcase
      end
    end else if (com[1]) begin
      if (wgm == `WGM_FAST && cntTick && count_ff == `CNT_MAX) begin
        nxt_pin = ~com[0];
      end else if (match) begin
        nxt_pin = com[0] ^ countDown_ff;
      end
    end
  end

  // =========================================
  // Timer state
  always @(posedge clk) begin
    if (!nrst) begin
      count_ff <= `RST_BYTE;
      countDown_ff <= 1'b0;
      blockMatch_ff <= 1'b0;
      compareOutputPin <= 1'b0;
    end else begin
      compareOutputPin <= nxt_pin;
      if (wrCount) begin
        count_ff <= wrData;
        blockMatch_ff <= 1'b1;
      end else begin
        count_ff <= nxt_count;
        countDown_ff <= nxt_down;
        if (cntTick) begin
          blockMatch_ff <= 1'b0;
        end
      end
    end
  end

  // =========================================
  // Async update path: temporaries move on a slow edge
  always @(posedge clk) begin
    if (!nrst) begin
      slowSync1_ff <= 1'b0;
      slowSync2_ff <= 1'b0;
      slowPrev_ff <= 1'b0;
      busy_ff <= 4'h0;
      compare_ff <= `RST_BYTE;
      ctrlAAct_ff <= `RST_BYTE;
      clkSelAct_ff <= 3'h0;
    end else begin
      slowSync1_ff <= slowClockTick;
      slowSync2_ff <= slowSync1_ff;
      slowPrev_ff <= slowSync2_ff;
      if (!asyncOn) begin
        busy_ff <= 4'h0;
        compare_ff <= compareTmp_ff;
        ctrlAAct_ff <= ctrlA_ff;
        clkSelAct_ff <= clkSel_ff;
      end else if (slowEdge) begin
        busy_ff <= 4'h0;
        compare_ff <= compareTmp_ff;
        ctrlAAct_ff <= ctrlA_ff;
        clkSelAct_ff <= clkSel_ff;
      end else begin
        if (wrCount) busy_ff[3] <= 1'b1;
        if (wrCmp) busy_ff[2] <= 1'b1;
        if (wrCtrlA) busy_ff[1] <= 1'b1;
        if (wrCtrlB) busy_ff[0] <= 1'b1;
      end
    end
  end

  // Busy crossing into the register view; the event stages carry a constant zero
  always @(posedge clk) begin
    if (!nrst) begin
      busyStage1_ff <= 4'h0;
      busyStage2_ff <= 4'h0;
      evtSync1_ff <= 1'b0;
      evtSync2_ff <= 1'b0;
    end else begin
      busyStage1_ff <= busy_ff | {wrCount, wrCmp, wrCtrlA, wrCtrlB} &
        {4{asyncOn}};
      busyStage2_ff <= busyStage1_ff;
      evtSync1_ff <= 1'b0;
      evtSync2_ff <= evtSync1_ff;
    end
  end

  // =========================================
  // Software registers and flags
  always @(posedge clk) begin
    if (!nrst) begin
      ctrlA_ff <= `RST_BYTE;
      clkSel_ff <= 3'h0;
      compareTmp_ff <= `RST_BYTE;
      extEn_ff <= 1'b0;
      asyncSel_ff <= 1'b0;
      irqMask_ff <= 2'b00;
      cmpFlag_ff <= 1'b0;
      ovfFlag_ff <= 1'b0;
    end else begin
      if (wrCtrlA) ctrlA_ff <= wrData & 8'hC3;
      if (wrCtrlB) clkSel_ff <= wrData[2:0];
      if (wrCmp) compareTmp_ff <= wrData;
      if (wrStb && addr == `ADDR_ASYNC_STAT) begin
        extEn_ff <= wrData[`ASR_EXT_BIT];
        asyncSel_ff <= wrData[`ASR_ASYNC_BIT] & sysClkIsRc;
      end else if (!sysClkIsRc) begin
        asyncSel_ff <= 1'b0;
      end
      if (wrStb && addr == `ADDR_IRQ_MASK) irqMask_ff <= wrData[1:0];
      // Set wins over clear; forced compare never sets
      if (match) begin
        cmpFlag_ff <= 1'b1;
      end else if (compareVectorAck || (wrStb && addr == `ADDR_IRQ_FLAG &&
          wrData[`IRQ_CMP_BIT])) begin
        cmpFlag_ff <= 1'b0;
      end
      if (ovfEvt && !wrCount) begin
        ovfFlag_ff <= 1'b1;
      end else if (overflowVectorAck || (wrStb && addr == `ADDR_IRQ_FLAG &&
          wrData[`IRQ_OVF_BIT])) begin
        ovfFlag_ff <= 1'b0;
      end
    end
  end

  // =========================================
  // Outputs and read port
  reg [7:0] rdMux;

  always @* begin
    case (addr)
      `ADDR_CTRL_A: rdMux = ctrlA_ff;
      `ADDR_CTRL_B: rdMux = {5'h00, clkSel_ff};
      `ADDR_COUNT: rdMux = count_ff;
      `ADDR_COMPARE: rdMux = compareTmp_ff;
      `ADDR_ASYNC_STAT: rdMux = {1'b0, extEn_ff, asyncSel_ff,
        busyStage2_ff[3], busyStage2_ff[2], 1'b0, busyStage2_ff[1],
        busyStage2_ff[0]};
      `ADDR_IRQ_MASK: rdMux = {6'h00, irqMask_ff};
      `ADDR_IRQ_FLAG: rdMux = {6'h00, cmpFlag_ff, ovfFlag_ff};
      `ADDR_SYS_CLK: rdMux = {7'h00, sysClkIsRc};
      default: rdMux = `RST_BYTE;
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      rdData <= `RST_BYTE;
      compareIrq <= 1'b0;
      overflowIrq <= 1'b0;
      extClockBufferEn <= 1'b0;
      crystalOscEn <= 1'b0;
    end else begin
      rdData <= rdStb ? rdMux : `RST_BYTE;
      compareIrq <= cmpFlag_ff & irqMask_ff[1] & globalIrqEnable;
      overflowIrq <= ovfFlag_ff & irqMask_ff[0] & globalIrqEnable;
      extClockBufferEn <= extEn_ff & asyncSel_ff;
      crystalOscEn <= asyncSel_ff & ~extEn_ff;
    end
  end
endmodule // async_8bit_timer
`default_nettype wire

// ==== async_8bit_timer_regs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.vh"
// ========================================
// Port checker
module async_8bit_timer_regs_checker (
  // Clock, reset, register port
  input wire clk,
  input wire nrst,
  input wire [3:0] addr,
  input wire rdStb,
  input wire [7:0] rdData,
  // Context and outputs
  input wire globalIrqEnable,
  input wire sysClkIsRc,
  input wire compareIrq,
  input wire overflowIrq,
  input wire extClockBufferEn,
  input wire crystalOscEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rd_idle_zero: assert property (!$past(rdStb) |-> rdData == 8'h00)
    else $error("read data not zero outside read");
  a_ctrlb_reserved: assert property ($past(rdStb) &&
    $past(addr) == `ADDR_CTRL_B |-> rdData[7:3] == 5'h00)
    else $error("control b upper bits not zero");
  a_stat_reserved: assert property ($past(rdStb) &&
    $past(addr) == `ADDR_ASYNC_STAT |-> !rdData[7] && !rdData[2])
    else $error("status reserved bits not zero");
  a_mask_reserved: assert property ($past(rdStb) &&
    $past(addr) == `ADDR_IRQ_MASK |-> rdData[7:2] == 6'h00)
    else $error("mask reserved bits not zero");
  a_clk_exclusive: assert property (!(extClockBufferEn && crystalOscEn))
    else $error("buffer and oscillator both on");
  a_async_no_rc: assert property (!sysClkIsRc [*4] |->
    !extClockBufferEn && !crystalOscEn)
    else $error("slow clock used without rc clock");
  a_cmp_irq_gate: assert property (compareIrq |-> $past(globalIrqEnable))
    else $error("compare irq without global enable");
  a_ovf_irq_gate: assert property (overflowIrq |-> $past(globalIrqEnable))
    else $error("overflow irq without global enable");
endmodule // async_8bit_timer_regs_checker
bind async_8bit_timer async_8bit_timer_regs_checker i_chk (.*);
`default_nettype wire

// ==== async_8bit_timer_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_regs.vh"
module async_8bit_timer_regs_test;
  logic clk = 0, nrst = 0, wrStb = 0, rdStb = 0, slowClockTick = 0;
  logic globalIrqEnable = 0, sysClkIsRc = 0, slowRun = 0;
  logic compareVectorAck = 0, overflowVectorAck = 0;
  logic [3:0] addr = 0;
  logic [7:0] wrData = 0, rdData, r, v;
  logic compareOutputPin, compareIrq, overflowIrq;
  logic extClockBufferEn, crystalOscEn;
  int n_mismatch = 0, samples_checked = 0, cycles = 0, i, j, k;
  int seed = 32'hc6ee59a1;
  int divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [3:0] ra [4] = '{`ADDR_COMPARE, `ADDR_COUNT, `ADDR_CTRL_A, `ADDR_CTRL_B};
  logic [7:0] ub [4] = '{8'h08, 8'h10, 8'h02, 8'h01};
  async_8bit_timer i_dut (.*);
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (slowRun && cycles % 8 == 0) slowClockTick <= ~slowClockTick;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 d = rdData;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 16; i++) if (i != 7) begin
      rd(4'(i), r);
      chk("reset value", 8'h00, r);
    end
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(`ADDR_COMPARE, v);
      rd(`ADDR_COMPARE, r);
      chk("compare", v, r);
      wr(`ADDR_CTRL_B, v & 8'h78);
      rd(`ADDR_CTRL_B, r);
      chk("ctrl b", 8'h00, r);
      wr(`ADDR_IRQ_MASK, v);
      rd(`ADDR_IRQ_MASK, r);
      chk("mask", v & 8'h03, r);
    end
    wr(`ADDR_IRQ_MASK, 8'h00);
    $display("test registers done");
    wr(`ADDR_CTRL_A, 8'h40);
    wr(`ADDR_CTRL_B, 8'h80);
    tick(3);
    chk("pin toggle", 8'h01, compareOutputPin);
    rd(`ADDR_IRQ_FLAG, r);
    chk("no flag", 8'h00, r);
    wr(`ADDR_COUNT, 8'h05);
    wr(`ADDR_CTRL_A, 8'h82);
    wr(`ADDR_CTRL_B, 8'h80);
    tick(3);
    chk("pin clear", 8'h00, compareOutputPin);
    rd(`ADDR_COUNT, r);
    chk("no ctc clear", 8'h05, r);
    wr(`ADDR_CTRL_A, 8'hC3);
    wr(`ADDR_CTRL_B, 8'h80);
    tick(3);
    chk("pwm force", 8'h00, compareOutputPin);
    wr(`ADDR_CTRL_A, 8'h00);
    $display("test force done");
    for (k = 0; k < 8; k++) begin
      wr(`ADDR_CTRL_B, 8'h00);
      wr(`ADDR_COUNT, 8'h00);
      wr(`ADDR_CTRL_B, 8'(k));
      repeat (k ? 4 * divs[k] : 40) @(posedge clk);
      rd(`ADDR_COUNT, r);
      if (k == 0) chk("stopped", 8'h00, r);
      else chk("tick span", 8'h01, 8'(r >= 3 && r <= 6));
    end
    $display("test prescaler done");
    wr(`ADDR_COMPARE, 8'h10);
    wr(`ADDR_COUNT, 8'hF0);
    wr(`ADDR_IRQ_FLAG, 8'h03);
    wr(`ADDR_IRQ_MASK, 8'h03);
    globalIrqEnable <= 1'b1;
    wr(`ADDR_CTRL_B, 8'h01);
    for (i = 0; i < 100 && overflowIrq !== 1'b1; i++) @(posedge clk);
    tick(1);
    chk("overflow irq", 8'h01, overflowIrq);
    for (i = 0; i < 100 && compareIrq !== 1'b1; i++) @(posedge clk);
    tick(1);
    chk("compare irq", 8'h01, compareIrq);
    @(posedge clk);
    compareVectorAck <= 1'b1;
    @(posedge clk);
    compareVectorAck <= 1'b0;
    wr(`ADDR_IRQ_FLAG, 8'h01);
    tick(3);
    chk("irqs cleared", 8'h00, {compareIrq, overflowIrq});
    wr(`ADDR_COUNT, 8'h10);
    tick(3);
    rd(`ADDR_IRQ_FLAG, r);
    chk("match blocked", 8'h00, r & 8'h02);
    wr(`ADDR_CTRL_B, 8'h00);
    globalIrqEnable <= 1'b0;
    $display("test interrupts done");
    sysClkIsRc <= 1'b1;
    wr(`ADDR_ASYNC_STAT, 8'h40);
    wr(`ADDR_ASYNC_STAT, 8'h60);
    tick(3);
    chk("ext buffer", 8'h01, extClockBufferEn);
    for (j = 0; j < 4; j++) begin
      slowRun = 0;
      wr(ra[j], 8'h00);
      tick(4);
      rd(`ADDR_ASYNC_STAT, r);
      chk("busy set", ub[j], r & ub[j]);
      slowRun = 1;
      for (i = 0; i < 30 && (r & ub[j]) != 0; i++) rd(`ADDR_ASYNC_STAT, r);
      chk("busy clear", 8'h00, r & ub[j]);
    end
    wr(`ADDR_ASYNC_STAT, 8'h00);
    wr(`ADDR_ASYNC_STAT, 8'h20);
    tick(3);
    chk("crystal on", 8'h01, crystalOscEn);
    sysClkIsRc <= 1'b0;
    tick(6);
    rd(`ADDR_ASYNC_STAT, r);
    chk("async forced", 8'h00, r & 8'h20);
    wr(`ADDR_ASYNC_STAT, 8'h20);
    rd(`ADDR_ASYNC_STAT, r);
    chk("async refused", 8'h00, r & 8'h20);
    $display("test async done");
    test_done();
  end
endmodule // async_8bit_timer_regs_test
`default_nettype wire
